// [verilog/iflrs_pkg.sv]
/*
  Constants shared by the input FIFO level/reset/status block.
  Assumes a single system clock; all other rates are enable pulses.
*/
package iflrs_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [7:0] REG_SYNC_CTRL = 8'h10;
  localparam logic [7:0] REG_DLY_SEL = 8'h16;
  localparam logic [7:0] REG_START_PH = 8'h17;
  localparam logic [7:0] REG_INIT_STAT = 8'h18;
  localparam logic [7:0] REG_LEVEL = 8'h19;
  localparam logic [7:0] REG_SED_PAT = 8'h20;
  localparam logic [7:0] REG_SED_CTRL = 8'h21;
  // ==========================================================
  // Field positions
  localparam int SYNC_RATE_BIT = 6;
  localparam int SYNC_EDGE_BIT = 3;
  localparam int IFMODE_LSB = 0;
  localparam int STAT_WARN_BIT = 7;
  localparam int STAT_ABS_BIT = 6;
  localparam int STAT_FRAME_BIT = 5;
  localparam int STAT_OK_BIT = 4;
  localparam int STAT_ACK_BIT = 2;
  localparam int STAT_REQ_BIT = 1;
  localparam int SED_ERR_BIT = 0;
  localparam int SED_EN_BIT = 1;
  // ==========================================================
  // Reset values and encodings
  localparam logic [7:0] SYNC_CTRL_RST = 8'h40;
  localparam logic [7:0] START_PH_RST = 8'h04;
  localparam logic [2:0] LVL_NEAR_EMPTY = 3'h1;
  localparam logic [2:0] LVL_NEAR_FULL = 3'h7;
  localparam logic [1:0] IF_WORD = 2'h0;
  localparam logic [1:0] IF_BYTE = 2'h1;
  localparam logic [1:0] IF_NIBBLE = 2'h2;
  localparam logic [3:0] BEATS_WORD = 4'h2;
  localparam logic [3:0] BEATS_BYTE = 4'h4;
  localparam logic [3:0] BEATS_NIBBLE = 4'h8;
  // ==========================================================
  // Timing: system clock and converter read rate
  localparam int CLK_PERIOD_NS = 100;
  localparam int CONV_PERIOD_NS = 800;
  localparam int CONV_DIV_CYC = CONV_PERIOD_NS / CLK_PERIOD_NS;
  // Serial-port handshake states
  typedef enum logic [2:0] {
    HS_IDLE = 3'b001,
    HS_PEND = 3'b010,
    HS_ACK = 3'b100
  } iflrs_hs_t;
endpackage

// [verilog/iflrs_sync.sv]
/*
  Two-flop synchroniser for a group of pin inputs.
  Assumes inputs are asynchronous to CLK_SYS; only stage two is read.
*/
`timescale 1ns/1ps
module iflrs_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Data
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_q;
  // ==========================================================
  // Two stages
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= '0;
      dout <= '0;
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule // iflrs_sync

// [verilog/iflrs_top.sv]
/*
  Input FIFO of a dual-channel converter data port: level reset by strobe,
  align input, serial request, warning flag, thermometer level, sample check.
  Assumes link pins are asynchronous and sampled by CLK_SYS; the converter
  sample clock is modelled by an internal divider enable.
*/
`timescale 1ns/1ps
module iflrs_top import iflrs_pkg::*; #(
  parameter int DEPTH = 8,
  parameter int CONV_DIV = CONV_DIV_CYC
) (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST,
  // Link pins
  input wire logic SOURCE_DATA_CLOCK,
  input wire logic [15:0] DATA,
  input wire logic FRAME,
  input wire logic REFERENCE_ALIGN_INPUT,
  // Register port
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  output logic [7:0] REG_RDATA,
  // Converter side
  output logic [15:0] DAC_I,
  output logic [15:0] DAC_Q,
  output logic FIFO_WARN
);
  if (DEPTH != 8 || CONV_DIV < 2 || CONV_DIV > 256) begin : g_bad_param
    $error("iflrs_top: unsupported DEPTH or CONV_DIV");
  end
  // ==========================================================
  // Pin synchronisers
  logic [18:0] pin_s;
  iflrs_sync #(.W(19)) u_sync (
    .clk(CLK_SYS),
    .rst(RST),
    .din({SOURCE_DATA_CLOCK, FRAME, REFERENCE_ALIGN_INPUT, DATA[15:0]}),
    .dout(pin_s)
  );
  logic dci_s, frame_s, align_s;
  logic [15:0] data_s;
  assign dci_s = pin_s[18];
  assign frame_s = pin_s[17];
  assign align_s = pin_s[16];
  assign data_s = pin_s[15:0];
  // ==========================================================
  // State
  logic [31:0] mem_q [DEPTH];
  logic dci_q, dci_d, align_q, align_d, align_pend_q, align_pend_d;
  logic [7:0] sync_q, sync_d, dly_q, dly_d, ph_q, ph_d, sedpat_q, sedpat_d;
  logic req_q, req_d, ok_q, ok_d, byframe_q, byframe_d, abs_q, abs_d;
  logic rel_pend_q, rel_pend_d, sed_en_q, sed_en_d, sed_err_q, sed_err_d;
  logic [2:0] wptr_q, wptr_d, rptr_q, rptr_d;
  logic [3:0] beat_q, beat_d, fhigh_q, fhigh_d;
  logic [15:0] iacc_q, iacc_d, qacc_q, qacc_d;
  logic [6:0] therm_q, therm_d;
  logic [7:0] div_q, div_d, rdata_d;
  logic [15:0] dac_i_d, dac_q_d;
  logic warn_d, conv_rise, conv_fall, edge_any, wr_pair, strobe_done, align_take;
  logic data_rate, rel_apply;
  logic [1:0] ifmode;
  logic [3:0] beats;
  logic [2:0] ph_set;
  iflrs_hs_t hs_q, hs_d;
  assign data_rate = sync_q[SYNC_RATE_BIT];
  assign ifmode = sync_q[IFMODE_LSB +: 2];
  assign ph_set = ph_q[2:0];
  assign beats = (ifmode == IF_WORD) ? BEATS_WORD :
                 (ifmode == IF_BYTE) ? BEATS_BYTE : BEATS_NIBBLE;
  // Converter clock: rise at count 0, fall at half period
  assign conv_rise = (div_q == 8'h00);
  assign conv_fall = (div_q == 8'(CONV_DIV / 2));
  assign edge_any = (dci_s != dci_q);
  // Bus slice for one beat
  function automatic logic [15:0] beat_bits(input logic [1:0] m, input logic [15:0] d);
    if (m == IF_BYTE)
      beat_bits = {8'h00, d[14], d[12], d[10], d[8], d[7], d[5], d[3], d[1]};
    else
      beat_bits = {12'h000, d[10], d[8], d[7], d[5]};
  endfunction
  // ==========================================================
  // Next-state logic
  always_comb begin
    logic [15:0] bb;
    bb = beat_bits(ifmode, data_s);
    dci_d = dci_s;
    align_d = align_s;
    div_d = (div_q == 8'(CONV_DIV - 1)) ? 8'h00 : div_q + 8'h01;
    beat_d = beat_q;
    fhigh_d = fhigh_q;
    iacc_d = iacc_q;
    qacc_d = qacc_q;
    wr_pair = 1'b0;
    strobe_done = 1'b0;
    if (edge_any) begin
      // Word: SOURCE_DATA_CLOCK high carries I; byte/nibble: strobe level routes
      if (ifmode == IF_WORD) begin
        if (dci_s) iacc_d = data_s;
        else qacc_d = data_s;
        beat_d = dci_s ? 4'h0 : beat_q + 4'h1;
      end else begin
        if (frame_s) iacc_d = (ifmode == IF_BYTE) ? {iacc_q[7:0], bb[7:0]}
                                                  : {iacc_q[11:0], bb[3:0]};
        else qacc_d = (ifmode == IF_BYTE) ? {qacc_q[7:0], bb[7:0]}
                                          : {qacc_q[11:0], bb[3:0]};
        beat_d = (frame_s && fhigh_q == 4'h0) ? 4'h0 : beat_q + 4'h1;
      end
      wr_pair = (beat_d == beats - 4'h1);
      // Strobe counts as init only after a full load held high
      fhigh_d = frame_s ? ((fhigh_q == beats) ? fhigh_q : fhigh_q + 4'h1) : 4'h0;
      strobe_done = frame_s && (fhigh_q == beats - 4'h1);
    end
    // Align sampling on the selected converter edge
    align_pend_d = align_pend_q | (align_s & ~align_q);
    align_take = align_pend_q && !data_rate
                 && (sync_q[SYNC_EDGE_BIT] ? conv_fall : conv_rise);
    if (align_take || data_rate) align_pend_d = 1'b0;
    // Read pointer
    rptr_d = rptr_q;
    if (align_take) rptr_d = 3'h0;
    else if (conv_rise) rptr_d = rptr_q + 3'h1;
    // Registers written by software
    sync_d = sync_q;
    dly_d = dly_q;
    ph_d = ph_q;
    req_d = req_q;
    sedpat_d = sedpat_q;
    sed_en_d = sed_en_q;
    if (REG_WR) begin
      case (REG_ADDR)
        REG_SYNC_CTRL: sync_d = REG_WDATA;
        REG_DLY_SEL: dly_d = REG_WDATA;
        REG_START_PH: ph_d = REG_WDATA;
        REG_INIT_STAT: req_d = REG_WDATA[STAT_REQ_BIT];
        REG_SED_PAT: sedpat_d = REG_WDATA;
        REG_SED_CTRL: sed_en_d = REG_WDATA[SED_EN_BIT];
        default: ;
      endcase
    end
    // Serial handshake
    hs_d = hs_q;
    rel_pend_d = rel_pend_q;
    ok_d = ok_q;
    byframe_d = byframe_q;
    abs_d = abs_q;
    case (hs_q)
      HS_IDLE: if (req_q) begin
        hs_d = HS_PEND;
        rel_pend_d = 1'b1;
        ok_d = 1'b0;
        byframe_d = 1'b0;
        abs_d = 1'b0;
      end
      HS_PEND: if (!rel_pend_q) hs_d = HS_ACK;
      HS_ACK: if (!req_q) hs_d = HS_IDLE;
      default: hs_d = HS_IDLE;
    endcase
    if (strobe_done && data_rate) begin
      rel_pend_d = 1'b1;
      ok_d = 1'b0;
      byframe_d = 1'b1;
      abs_d = 1'b0;
    end
    // Write pointer: reset beats increment
    wptr_d = wr_pair ? wptr_q + 3'h1 : wptr_q;
    rel_apply = rel_pend_q && conv_rise && (rptr_d == 3'h0);
    if (strobe_done && !data_rate) begin
      wptr_d = ph_set;
      ok_d = 1'b1;
      byframe_d = 1'b1;
      abs_d = 1'b1;
    end else if (rel_apply) begin
      wptr_d = ph_set;
      rel_pend_d = 1'b0;
      ok_d = 1'b1;
    end
    // Level seen at read zero as thermometer
    therm_d = (conv_rise && rptr_d == 3'h0) ? 7'((8'h01 << wptr_q) - 8'h01) : therm_q;
    warn_d = (wptr_q - rptr_q == LVL_NEAR_EMPTY) || (wptr_q - rptr_q == LVL_NEAR_FULL);
    // Sample checker on each written I word; set wins over clear
    sed_err_d = sed_err_q;
    if (REG_WR && REG_ADDR == REG_SED_CTRL && REG_WDATA[SED_ERR_BIT]) sed_err_d = 1'b0;
    if (sed_en_q && wr_pair && iacc_d[7:0] != sedpat_q) sed_err_d = 1'b1;
    // Data rate mode reads the one slot just written; FIFO rate reads rptr
    dac_i_d = DAC_I;
    dac_q_d = DAC_Q;
    if (conv_rise) begin
      {dac_i_d, dac_q_d} = data_rate ? mem_q[wptr_q - 3'h1] : mem_q[rptr_d];
    end
    // Readback
    case (REG_ADDR)
      REG_SYNC_CTRL: rdata_d = sync_q;
      REG_DLY_SEL: rdata_d = dly_q;
      REG_START_PH: rdata_d = ph_q;
      REG_INIT_STAT: rdata_d = {FIFO_WARN, abs_q, byframe_q, ok_q, 1'b0,
                               (hs_q == HS_ACK), req_q, 1'b0};
      REG_LEVEL: rdata_d = {1'b0, therm_q};
      REG_SED_PAT: rdata_d = sedpat_q;
      REG_SED_CTRL: rdata_d = {6'h00, sed_en_q, sed_err_q};
      default: rdata_d = 8'h00;
    endcase
  end
  // ==========================================================
  // Registers
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      dci_q <= 1'b0;
      align_q <= 1'b0;
      align_pend_q <= 1'b0;
      div_q <= 8'h00;
      beat_q <= 4'h0;
      fhigh_q <= 4'h0;
      iacc_q <= 16'h0000;
      qacc_q <= 16'h0000;
      rptr_q <= 3'h0;
      wptr_q <= START_PH_RST[2:0];
      sync_q <= SYNC_CTRL_RST;
      dly_q <= 8'h00;
      ph_q <= START_PH_RST;
      req_q <= 1'b0;
      sedpat_q <= 8'h00;
      sed_en_q <= 1'b0;
      sed_err_q <= 1'b0;
      hs_q <= HS_IDLE;
      rel_pend_q <= 1'b0;
      ok_q <= 1'b0;
      byframe_q <= 1'b0;
      abs_q <= 1'b0;
      therm_q <= 7'h00;
      FIFO_WARN <= 1'b0;
      REG_RDATA <= 8'h00;
      DAC_I <= 16'h0000;
      DAC_Q <= 16'h0000;
    end else begin
      dci_q <= dci_d;
      align_q <= align_d;
      align_pend_q <= align_pend_d;
      div_q <= div_d;
      beat_q <= beat_d;
      fhigh_q <= fhigh_d;
      iacc_q <= iacc_d;
      qacc_q <= qacc_d;
      rptr_q <= rptr_d;
      wptr_q <= wptr_d;
      sync_q <= sync_d;
      dly_q <= dly_d;
      ph_q <= ph_d;
      req_q <= req_d;
      sedpat_q <= sedpat_d;
      sed_en_q <= sed_en_d;
      sed_err_q <= sed_err_d;
      hs_q <= hs_d;
      rel_pend_q <= rel_pend_d;
      ok_q <= ok_d;
      byframe_q <= byframe_d;
      abs_q <= abs_d;
      therm_q <= therm_d;
      FIFO_WARN <= warn_d;
      REG_RDATA <= rdata_d;
      DAC_I <= dac_i_d;
      DAC_Q <= dac_q_d;
    end
  end
  // FIFO storage, no reset needed
  always_ff @(posedge CLK_SYS) begin
    if (wr_pair) mem_q[wptr_q] <= {iacc_d, qacc_d};
  end
  // ==========================================================
  // Checks
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  rel_reset_a: assert property (rel_pend_q && conv_rise && rptr_d == 3'h0 && !strobe_done |=> wptr_q == $past(ph_q[2:0]) && !rel_pend_q) else $error("relative reset missed");
  align_rptr_a: assert property (align_take |=> rptr_q == 3'h0) else $error("align did not clear read pointer");
  align_edge_a: assert property (!conv_rise && rptr_d != rptr_q |-> sync_q[SYNC_EDGE_BIT] && conv_fall && rptr_d == 3'h0) else $error("align on wrong edge");
  abs_reset_a: assert property (strobe_done && !data_rate |=> wptr_q == $past(ph_q[2:0]) && abs_q && ok_q) else $error("absolute reset missed");
  mode_select_a: assert property (strobe_done && data_rate |=> rel_pend_q && !abs_q) else $error("strobe in data rate mode not relative");
  warn_flag_a: assert property ((wptr_q - rptr_q) == LVL_NEAR_FULL || (wptr_q - rptr_q) == LVL_NEAR_EMPTY |=> FIFO_WARN) else $error("warning flag not set");
  therm_code_a: assert property (conv_rise && rptr_d == 3'h0 |=> $countones(therm_q) == $past(wptr_q) && ((therm_q & (therm_q + 7'h01)) == 7'h00)) else $error("thermometer level wrong");
  ack_drop_a: assert property (hs_q == HS_ACK && !req_q |=> hs_q == HS_IDLE ##1 $past(REG_ADDR) != REG_INIT_STAT || !REG_RDATA[STAT_ACK_BIT]) else $error("acknowledge did not drop");
  sed_flag_a: assert property (sed_en_q && wr_pair && iacc_d[7:0] != sedpat_q |=> sed_err_q) else $error("sample error not flagged");
endmodule // iflrs_top

// [test/iflrs_src_model.sv]
/*
  Behavioural model of the data source that drives the link pins.
  Assumes the bench calls its tasks; link clock idles low between frames.
*/
`timescale 1ns/1ps
module iflrs_src_model (
  // Link pins
  output logic source_data_clock,
  output logic [15:0] data,
  output logic frame
);
  // ==========================================================
  // Pin start-up values
  initial begin
    source_data_clock = 1'b0;
    data = 16'h0000;
    frame = 1'b0;
  end
  // One beat: data settles, clock edge, data held well past the edge
  task automatic beat(input logic [15:0] d, input logic f);
    data = d;
    frame = f;
    #100;
    source_data_clock = ~source_data_clock;
    #300;
  endtask
  // Released bus shows the inverse of the last value, strobe low
  task automatic idle();
    data = ~data;
    frame = 1'b0;
  endtask
  // Word load: I on rise, Q on fall; strobe held for the whole pair
  task automatic word(input logic [15:0] i, input logic [15:0] q, input logic strobe);
    beat(i, strobe);
    beat(q, strobe);
    idle();
  endtask
  // Byte lane pin map, MSB first
  function automatic logic [15:0] spread(input logic [7:0] b);
    logic [15:0] p;
    p = 16'h0000;
    {p[14], p[12], p[10], p[8], p[7], p[5], p[3], p[1]} = b;
    return p;
  endfunction
  // Byte load: strobe high carries I, low carries Q
  task automatic bytes(input logic [15:0] i, input logic [15:0] q);
    beat(spread(i[15:8]), 1'b1);
    beat(spread(i[7:0]), 1'b1);
    beat(spread(q[15:8]), 1'b0);
    beat(spread(q[7:0]), 1'b0);
    idle();
  endtask
  // Nibble lane pin map, MSB first
  function automatic logic [15:0] spread4(input logic [3:0] n);
    logic [15:0] p;
    p = 16'h0000;
    {p[10], p[8], p[7], p[5]} = n;
    return p;
  endfunction
  // Nibble load: four I nibbles with strobe high, then four Q nibbles low
  task automatic nibbles(input logic [15:0] i, input logic [15:0] q);
    for (int k = 3; k >= 0; k--) beat(spread4(i[4*k +: 4]), 1'b1);
    for (int k = 3; k >= 0; k--) beat(spread4(q[4*k +: 4]), 1'b0);
    idle();
  endtask
endmodule // iflrs_src_model

// [test/tb_top.sv]
/*
  Self-checking bench for the input FIFO level/reset/status block.
  Assumes the source model on the link pins and register access by address.
*/
`timescale 1ns/1ps
module tb_top import iflrs_pkg::*;
  ;
  // ==========================================================
  // Signals
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic align = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic [7:0] rdata;
  logic [15:0] dac_i, dac_q;
  logic source_data_clock, frame, warn;
  logic [15:0] data;
  int mismatches = 0;
  int samples_checked = 0;
  // Clock
  initial begin
    forever #50 clk = ~clk;
  end
  // Device and source
  iflrs_top uut (.CLK_SYS(clk), .RST(rst), .SOURCE_DATA_CLOCK(source_data_clock), .DATA(data),
    .FRAME(frame), .REFERENCE_ALIGN_INPUT(align), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_WR(wr), .REG_RDATA(rdata), .DAC_I(dac_i), .DAC_Q(dac_q), .FIFO_WARN(warn));
  iflrs_src_model src (.source_data_clock(source_data_clock), .data(data), .frame(frame));
  // ==========================================================
  // Compare and access tasks
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    addr = a;
    repeat (2) @(negedge clk);
    d = rdata;
  endtask
  task automatic creg(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
    logic [7:0] d;
    rreg(a, d);
    chk($sformatf("reg %h", a), {8'h00, exp}, {8'h00, d & m});
  endtask
  // Poll a register field under a bounded count
  task automatic poll(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
    logic [7:0] d;
    int n;
    n = 0;
    rreg(a, d);
    while ((d & m) !== exp && n < 200) begin
      rreg(a, d);
      n++;
    end
    chk($sformatf("poll %h", a), {8'h00, exp}, {8'h00, d & m});
  endtask
  // Wait for an I word to reach the converter side, then check both
  task automatic dacw(input logic [15:0] ei, input logic [15:0] eq);
    int n;
    n = 0;
    while (dac_i !== ei && n < 300) begin
      @(negedge clk);
      n++;
    end
    chk("DAC_I", ei, dac_i);
    chk("DAC_Q", eq, dac_q);
  endtask
  // Count warning cycles over one full turn of the read pointer, no traffic
  task automatic cwarn();
    int n;
    n = 0;
    repeat (8 * CONV_DIV_CYC) begin
      @(negedge clk);
      if (warn === 1'b1) n++;
    end
    chk("FIFO_WARN cycles", 16'(2 * CONV_DIV_CYC), 16'(n));
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Watchdog well beyond the expected run
  initial begin
    #3000000;
    mismatches++;
    results();
  end
  // ==========================================================
  // Test sequence
  initial begin
    repeat (3) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    // Reset values, read-only and unmapped places
    creg(REG_SYNC_CTRL, 8'hFF, 8'h40);
    creg(REG_START_PH, 8'hFF, 8'h04);
    creg(REG_DLY_SEL, 8'hFF, 8'h00);
    creg(8'h33, 8'hFF, 8'h00);
    wreg(REG_DLY_SEL, 8'hA5);
    creg(REG_DLY_SEL, 8'hFF, 8'hA5);
    repeat (40) @(negedge clk);
    creg(REG_LEVEL, 8'hFF, 8'h0F);
    wreg(REG_LEVEL, 8'h00);
    creg(REG_LEVEL, 8'hFF, 8'h0F);
    // Serial relative reset to start level 6
    wreg(REG_START_PH, 8'h06);
    wreg(REG_INIT_STAT, 8'h02);
    poll(REG_INIT_STAT, 8'h04, 8'h04);
    wreg(REG_INIT_STAT, 8'h00);
    poll(REG_INIT_STAT, 8'h04, 8'h00);
    repeat (80) @(negedge clk);
    creg(REG_LEVEL, 8'hFF, 8'h3F);
    // FIFO rate mode: absolute reset by a full-load strobe
    wreg(REG_SYNC_CTRL, 8'h00);
    wreg(REG_START_PH, 8'h03);
    src.word(16'h1234, 16'hABCD, 1'b1);
    repeat (80) @(negedge clk);
    creg(REG_INIT_STAT, 8'h70, 8'h70);
    creg(REG_LEVEL, 8'hFF, 8'h07);
    cwarn();
    // Align on each converter edge choice, then word traffic
    wreg(REG_SYNC_CTRL, 8'h08);
    align = 1'b1;
    repeat (20) @(negedge clk);
    align = 1'b0;
    wreg(REG_SYNC_CTRL, 8'h00);
    align = 1'b1;
    repeat (20) @(negedge clk);
    align = 1'b0;
    src.word(16'h5A5A, 16'hC3C3, 1'b0);
    dacw(16'h5A5A, 16'hC3C3);
    // Byte mode routing by the strobe
    wreg(REG_SYNC_CTRL, 8'h01);
    src.bytes(16'h7E81, 16'h1F2E);
    dacw(16'h7E81, 16'h1F2E);
    // Sample checker: matching then mismatching low byte of I
    wreg(REG_SED_PAT, 8'h81);
    wreg(REG_SED_CTRL, 8'h03);
    src.bytes(16'h0081, 16'h0000);
    dacw(16'h0081, 16'h0000);
    creg(REG_SED_CTRL, 8'h01, 8'h00);
    src.bytes(16'h0082, 16'h0000);
    dacw(16'h0082, 16'h0000);
    creg(REG_SED_CTRL, 8'h01, 8'h01);
    // Nibble mode routing by the strobe
    wreg(REG_SYNC_CTRL, 8'h02);
    src.nibbles(16'hA5C3, 16'h3C5A);
    dacw(16'hA5C3, 16'h3C5A);
    // Data rate mode: a full-load strobe gives a relative reset
    wreg(REG_SYNC_CTRL, 8'h40);
    wreg(REG_START_PH, 8'h05);
    src.word(16'h0F0F, 16'hF0F0, 1'b1);
    dacw(16'h0F0F, 16'hF0F0);
    repeat (140) @(negedge clk);
    creg(REG_INIT_STAT, 8'h70, 8'h30);
    creg(REG_LEVEL, 8'hFF, 8'h1F);
    results();
  end
endmodule // tb_top
